/* File: shared/ctd_pkg.sv */
// Constants, register map and field types for the capture timer support block.
// Assumes a 32-bit AXI4-Lite master and a 20 MHz module clock.
package ctd_pkg;
   localparam int          DATA_W          = 32;
   localparam int          ADDR_W          = 8;
   // Register byte addresses
   localparam logic [7:0]  ACCUM_CNT_ADDR  = 8'hA0;
   localparam logic [7:0]  ACCUM_EN_ADDR   = 8'hA8;
   localparam logic [7:0]  MOD_CTL_ADDR    = 8'hB0;
   localparam logic [7:0]  MOD_FLAGS_ADDR  = 8'hB4;
   localparam logic [7:0]  MOD_COUNT_ADDR  = 8'hB8;
   localparam logic [7:0]  DELAY_CTL_ADDR  = 8'hBC;
   localparam logic [7:0]  SYS_CTL_ADDR    = 8'hC0;
   localparam logic [7:0]  ACCUM_FLG_ADDR  = 8'hC4;
   localparam logic [7:0]  ACCUM_HOLD_ADDR = 8'hC8;
   // Field positions
   localparam int          UNDERFLOW_BIT   = 7;
   localparam int          FIRST_OVF_BIT   = 1;
   localparam int          SECOND_OVF_BIT  = 0;
   localparam int          FORCE_LATCH_BIT = 4;
   localparam int          FORCE_LOAD_BIT  = 3;
   // Reset values
   localparam logic [15:0] COUNT_IDLE      = 16'hFFFF;
   localparam logic [15:0] LOAD_RESET      = 16'h0000;
   localparam logic [7:0]  BYTE_RESET      = 8'h00;
   // Filter delays in module clocks
   localparam int          DELAY_SHORT     = 256;
   localparam int          DELAY_MID       = 512;
   localparam int          DELAY_LONG      = 1024;
   localparam int          CLK_PERIOD_NS   = 50;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;

   typedef struct packed {
      logic       irq_enable;
      logic       modulus_mode_select;
      logic       read_load_select;
      logic       spare_latch;
      logic       spare_load;
      logic       modulus_counter_enable;
      logic [1:0] prescale;
   } ctd_mod_ctl_type;

   typedef struct packed {
      logic fast_flag_clear;
      logic capture_buffer_enable;
      logic latch_or_queue_select;
      logic wide_accum_second_enable;
      logic wide_accum_first_enable;
   } ctd_sys_ctl_type;
endpackage

/* File: verilog/ctd_timer_support.sv */
// Pulse accumulators, modulus down-counter and capture delay filters.
// Assumes capture pins are asynchronous and wide tick inputs are on aclk.
// Operation
// - First wide enable joins count three (high) and two (low).
// - Count three wrapping FF to 00 sets first overflow flag.
// - Second wide enable joins count one (high) and zero (low).
// - Count one wrapping FF to 00 sets second overflow flag.
// - Underflow interrupt only when flag set and its enable is one.
// - One-shot stops at zero; modulus mode reloads latest written value.
// - Count register read gives count, or load value when selected.
// - Force latch copies byte counts to holding registers, then clears counts.
// - Force latch write of zero does nothing; reads zero.
// - Force load copies load to count and resets prescaler when enabled.
// - Disabled counter holds all ones, avoiding early underflow.
// - Prescaler divides by 1, 4, 8, 16; new rate at next load.
// - Underflow flag bit 7 set at zero; write one clears.
// - Fast flag clear: a count register read, or a write with byte 0 strobe set, clears underflow flag.
// - Read-only polarity bits record first capture edge after latch read.
// - Byte enables count only while pair's wide enable is clear.
// - Filter pulses after delay only if level opposite to before.
// - Delay counter clears itself after its interval.
// - Latch mode also latches on zero reached or zero written.
module ctd_timer_support #(
   parameter int CHANNELS = 4
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic [CHANNELS-1:0]     capture_pin,
   input  wire logic                    wide_first_tick,
   input  wire logic                    wide_second_tick,
   output logic [CHANNELS-1:0]          capture_edge_q,
   output logic                         capture_latch_q,
   output logic                         mod_irq
);
   localparam int DCW = 11;
   logic [7:0] aw_addr_q, ar_addr;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q, wr_en, rd_en;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_mux;
   ctd_pkg::ctd_mod_ctl_type ctl_q;
   ctd_pkg::ctd_sys_ctl_type sys_q;
   logic [3:0] byte_en_q;
   logic [1:0] delay_sel_q;
   logic [15:0] count_q, load_q;
   logic [3:0] presc_q;
   logic [1:0] rate_q;
   logic underflow_q, first_ovf_q, second_ovf_q;
   logic [7:0] acc_q [CHANNELS];
   logic [7:0] hold_q [CHANNELS];
   logic [CHANNELS-1:0] sync1_q, sync2_q, prev_q, busy_q, prior_q;
   logic [CHANNELS-1:0] polarity_q, armed_q, edge_rise_q;
   logic [DCW-1:0] dcnt_q [CHANNELS];
   logic wr_count, acc_count, force_load, zero_reach, tick, latch_evt;
   logic ovf3, ovf1, acc_wr;

   function automatic logic [3:0] presc_last(input logic [1:0] code);
      case (code)
         2'h0:    presc_last = 4'h0;
         2'h1:    presc_last = 4'h3;
         2'h2:    presc_last = 4'h7;
         default: presc_last = 4'hF;
      endcase
   endfunction

   function automatic logic [DCW-1:0] delay_last(input logic [1:0] code);
      case (code)
         2'h1:    delay_last = DCW'(ctd_pkg::DELAY_SHORT - 1);
         2'h2:    delay_last = DCW'(ctd_pkg::DELAY_MID - 1);
         default: delay_last = DCW'(ctd_pkg::DELAY_LONG - 1);
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a[7:2] == reg_addr[7:2]);
   endfunction

   // AXI4-Lite write path
   assign s_axi_awready = ~aw_have_q;
   assign s_axi_wready  = ~w_have_q;
   assign wr_en = aw_have_q & w_have_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= ctd_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_en) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_en) begin
            w_have_q <= 1'b0;
         end
         if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q >= ctd_pkg::ACCUM_CNT_ADDR && aw_addr_q[7:2] != 6'h29
                         && aw_addr_q <= ctd_pkg::ACCUM_HOLD_ADDR + 8'h03)
                        ? ctd_pkg::RESP_OKAY : ctd_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read path
   assign ar_addr = s_axi_araddr;
   assign s_axi_arready = ~rvalid_q;
   assign rd_en = s_axi_arvalid & ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit(ar_addr, ctd_pkg::ACCUM_CNT_ADDR))
         rd_mux = {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
      else if (hit(ar_addr, ctd_pkg::ACCUM_EN_ADDR))
         rd_mux = {28'h0000000, byte_en_q};
      else if (hit(ar_addr, ctd_pkg::MOD_CTL_ADDR))
         rd_mux = {24'h000000, ctl_q & 8'hE7};
      else if (hit(ar_addr, ctd_pkg::MOD_FLAGS_ADDR))
         rd_mux = {24'h000000, underflow_q, 3'h0, polarity_q};
      else if (hit(ar_addr, ctd_pkg::MOD_COUNT_ADDR))
         rd_mux = {16'h0000, ctl_q.read_load_select ? load_q : count_q};
      else if (hit(ar_addr, ctd_pkg::DELAY_CTL_ADDR))
         rd_mux = {30'h00000000, delay_sel_q};
      else if (hit(ar_addr, ctd_pkg::SYS_CTL_ADDR))
         rd_mux = {27'h0000000, sys_q};
      else if (hit(ar_addr, ctd_pkg::ACCUM_FLG_ADDR))
         rd_mux = {30'h00000000, first_ovf_q, second_ovf_q};
      else if (hit(ar_addr, ctd_pkg::ACCUM_HOLD_ADDR))
         rd_mux = {hold_q[3], hold_q[2], hold_q[1], hold_q[0]};
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= ctd_pkg::RESP_OKAY;
      end else if (rd_en) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= (ar_addr >= ctd_pkg::ACCUM_CNT_ADDR && ar_addr[7:2] != 6'h29
                      && ar_addr <= ctd_pkg::ACCUM_HOLD_ADDR + 8'h03)
                     ? ctd_pkg::RESP_OKAY : ctd_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q       <= '0;
         sys_q       <= '0;
         byte_en_q   <= 4'h0;
         delay_sel_q <= 2'h0;
      end else if (wr_en && w_strb_q[0]) begin
         if (hit(aw_addr_q, ctd_pkg::MOD_CTL_ADDR))
            ctl_q <= ctd_pkg::ctd_mod_ctl_type'(w_data_q[7:0] & 8'hE7);
         if (hit(aw_addr_q, ctd_pkg::SYS_CTL_ADDR))
            sys_q <= ctd_pkg::ctd_sys_ctl_type'(w_data_q[4:0]);
         if (hit(aw_addr_q, ctd_pkg::ACCUM_EN_ADDR))
            byte_en_q <= w_data_q[3:0];
         if (hit(aw_addr_q, ctd_pkg::DELAY_CTL_ADDR))
            delay_sel_q <= w_data_q[1:0];
      end
   end

   // Modulus down-counter
   assign wr_count = wr_en && w_strb_q[0] && hit(aw_addr_q, ctd_pkg::MOD_COUNT_ADDR);
   assign acc_count = wr_count | (rd_en && hit(ar_addr, ctd_pkg::MOD_COUNT_ADDR));
   assign force_load = wr_en && w_strb_q[0] && hit(aw_addr_q, ctd_pkg::MOD_CTL_ADDR)
                       && w_data_q[ctd_pkg::FORCE_LOAD_BIT] && ctl_q.modulus_counter_enable;
   assign tick = (presc_q == presc_last(rate_q));
   assign zero_reach = ctl_q.modulus_counter_enable && tick && count_q == 16'h0001
                       && !wr_count && !force_load;
   assign latch_evt = sys_q.latch_or_queue_select && sys_q.capture_buffer_enable &&
      ((wr_en && w_strb_q[0] && hit(aw_addr_q, ctd_pkg::MOD_CTL_ADDR)
        && w_data_q[ctd_pkg::FORCE_LATCH_BIT]) || zero_reach
       || (wr_count && w_data_q[15:0] == 16'h0000));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= ctd_pkg::COUNT_IDLE;
         load_q  <= ctd_pkg::LOAD_RESET;
         presc_q <= 4'h0;
         rate_q  <= 2'h0;
      end else begin
         if (wr_count)
            load_q <= w_data_q[15:0];
         if (!ctl_q.modulus_counter_enable) begin
            count_q <= ctd_pkg::COUNT_IDLE;
            presc_q <= 4'h0;
         // load restarts prescaler and takes new rate
         end else if (wr_count || force_load) begin
            count_q <= wr_count ? w_data_q[15:0] : load_q;
            presc_q <= 4'h0;
            rate_q  <= ctl_q.prescale;
         end else begin
            presc_q <= tick ? 4'h0 : presc_q + 4'h1;
            if (zero_reach && ctl_q.modulus_mode_select) begin
               count_q <= load_q;
               rate_q  <= ctl_q.prescale;
            end else if (tick && count_q != 16'h0000) begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         underflow_q <= 1'b0;
      else if (zero_reach)
         underflow_q <= 1'b1;
      else if ((acc_count && sys_q.fast_flag_clear) || (wr_en && w_strb_q[0]
               && hit(aw_addr_q, ctd_pkg::MOD_FLAGS_ADDR) && w_data_q[ctd_pkg::UNDERFLOW_BIT]))
         underflow_q <= 1'b0;
   end
   assign mod_irq = underflow_q & ctl_q.irq_enable;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
         busy_q  <= '0;
         prior_q <= '0;
         capture_edge_q <= '0;
         edge_rise_q    <= '0;
         for (int i = 0; i < CHANNELS; i++)
            dcnt_q[i] <= '0;
      end else begin
         sync1_q <= capture_pin;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         for (int i = 0; i < CHANNELS; i++) begin
            capture_edge_q[i] <= 1'b0;
            if (delay_sel_q == 2'h0) begin
               busy_q[i] <= 1'b0;
               dcnt_q[i] <= '0;
               capture_edge_q[i] <= sync2_q[i] ^ prev_q[i];
               edge_rise_q[i] <= sync2_q[i];
            end else if (!busy_q[i]) begin
               if (sync2_q[i] != prev_q[i]) begin
                  busy_q[i]  <= 1'b1;
                  prior_q[i] <= prev_q[i];
               end
            end else if (dcnt_q[i] >= delay_last(delay_sel_q)) begin
               busy_q[i] <= 1'b0;
               dcnt_q[i] <= '0;
               capture_edge_q[i] <= sync2_q[i] != prior_q[i];
               edge_rise_q[i] <= sync2_q[i];
            end else begin
               dcnt_q[i] <= dcnt_q[i] + 1'b1;
            end
         end
      end
   end

   // first edge polarity after a latch or holding read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         polarity_q <= '0;
         armed_q    <= '1;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (capture_edge_q[i] && armed_q[i]) begin
               polarity_q[i] <= edge_rise_q[i];
               armed_q[i]    <= 1'b0;
            end else if (latch_evt || (rd_en && hit(ar_addr, ctd_pkg::ACCUM_HOLD_ADDR))) begin
               armed_q[i] <= 1'b1;
            end
         end
      end
   end

   // wrap detection
   // Software write of the high byte wins, so no wrap
   assign acc_wr = wr_en && hit(aw_addr_q, ctd_pkg::ACCUM_CNT_ADDR);
   assign ovf3 = acc_q[3] == 8'hFF && !(acc_wr && w_strb_q[3])
                 && (sys_q.wide_accum_first_enable
                 ? (wide_first_tick && acc_q[2] == 8'hFF) : (byte_en_q[3] && capture_edge_q[3]));
   assign ovf1 = acc_q[1] == 8'hFF && !(acc_wr && w_strb_q[1])
                 && (sys_q.wide_accum_second_enable
                 ? (wide_second_tick && acc_q[0] == 8'hFF) : (byte_en_q[1] && capture_edge_q[1]));

   // Accumulators: latch clear, then software write, then counting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_latch_q <= 1'b0;
         for (int i = 0; i < CHANNELS; i++) begin
            acc_q[i]  <= ctd_pkg::BYTE_RESET;
            hold_q[i] <= ctd_pkg::BYTE_RESET;
         end
      end else begin
         capture_latch_q <= latch_evt;
         for (int i = 0; i < CHANNELS; i++) begin
            if (latch_evt) begin
               hold_q[i] <= acc_q[i];
               acc_q[i]  <= ctd_pkg::BYTE_RESET;
            end else if (wr_en && w_strb_q[i] && hit(aw_addr_q, ctd_pkg::ACCUM_CNT_ADDR)) begin
               acc_q[i] <= w_data_q[8*i +: 8];
            // wide pairs carry low into high
            end else if (i >= 2 && sys_q.wide_accum_first_enable) begin
               if (wide_first_tick && (i == 2 || acc_q[2] == 8'hFF))
                  acc_q[i] <= acc_q[i] + 8'h01;
            end else if (i < 2 && sys_q.wide_accum_second_enable) begin
               if (wide_second_tick && (i == 0 || acc_q[0] == 8'hFF))
                  acc_q[i] <= acc_q[i] + 8'h01;
            end else if (byte_en_q[i] && capture_edge_q[i]) begin
               acc_q[i] <= acc_q[i] + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_ovf_q  <= 1'b0;
         second_ovf_q <= 1'b0;
      end else begin
         if (ovf3 && !latch_evt)
            first_ovf_q <= 1'b1;
         else if (wr_en && w_strb_q[0] && hit(aw_addr_q, ctd_pkg::ACCUM_FLG_ADDR)
                  && w_data_q[ctd_pkg::FIRST_OVF_BIT])
            first_ovf_q <= 1'b0;
         if (ovf1 && !latch_evt)
            second_ovf_q <= 1'b1;
         else if (wr_en && w_strb_q[0] && hit(aw_addr_q, ctd_pkg::ACCUM_FLG_ADDR)
                  && w_data_q[ctd_pkg::SECOND_OVF_BIT])
            second_ovf_q <= 1'b0;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_IDLE_ONES: assert property (!ctl_q.modulus_counter_enable |=> count_q == 16'hFFFF)
      else $error("Disabled counter not all ones");
   AST_IRQ_GATE: assert property (underflow_q && !ctl_q.irq_enable |-> !mod_irq)
      else $error("Interrupt without enable");
   AST_ZERO_FLAG: assert property (zero_reach |=> underflow_q ##0 count_q ==
      ($past(ctl_q.modulus_mode_select) ? $past(load_q) : 16'h0000))
      else $error("Underflow flag not set");
   AST_ONE_SHOT: assert property (ctl_q.modulus_counter_enable && !ctl_q.modulus_mode_select
      && count_q == 16'h0000 && !wr_count && !force_load |=> count_q == 16'h0000)
      else $error("One-shot left zero");
   AST_DECREMENT: assert property (ctl_q.modulus_counter_enable && tick
      && count_q > 16'h0001 && !wr_count && !force_load |=> count_q == $past(count_q) - 16'h0001)
      else $error("Count did not decrement");
   AST_FORCE_LOAD: assert property (force_load && !wr_count
      |=> count_q == $past(load_q) && presc_q == 4'h0)
      else $error("Force load failed");
   AST_LATCH: assert property (latch_evt |=> acc_q[3] == 8'h00
      && hold_q[3] == $past(acc_q[3]) && capture_latch_q)
      else $error("Latch did not move and clear");
   AST_FAST_CLR: assert property (acc_count && sys_q.fast_flag_clear && !zero_reach
      |=> !underflow_q)
      else $error("Fast clear missed");
   AST_WRAP3: assert property (ovf3 && !latch_evt |=> first_ovf_q && acc_q[3] == 8'h00)
      else $error("Overflow flag missed");
   AST_FILTER: assert property (busy_q[0] && delay_sel_q == 2'h1 && $stable(delay_sel_q)
      |-> ##[1:256] !busy_q[0])
      else $error("Delay counter did not clear");
   COV_UNDERFLOW: cover property (zero_reach && ctl_q.modulus_mode_select);
   COV_LATCH: cover property (latch_evt ##1 capture_latch_q);
   COV_FILTERED: cover property (busy_q[0] ##[1:600] capture_edge_q[0]);
endmodule

/* File: test/ctd_pin_model.sv */
// Far-side model of the capture input pins.
// The bench also spaces some edges closer than the filter delay, to check rejection.
module ctd_pin_model (
   input  wire logic [3:0] level_req,
   output logic      [3:0] capture_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial capture_pin = 4'h0;
   always @(level_req) capture_pin <= #13 level_req;
endmodule

/* File: test/test_capture_timer_counters_delay.sv */
// Self-checking bench for the capture timer support block.
// Assumes the design package and the pin model are compiled first.
module test_capture_timer_counters_delay;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick_a, tick_b;
   logic        awready, wready, bvalid, arready, rvalid, latch_q, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_q, rnd;
   logic [3:0]  wstrb, pin, lvl, edge_q;
   logic [1:0]  bresp, rresp, resp_q;
   int          n_fail, num_checks, n_latch, seed, k, t, dly;

   ctd_pin_model pins (.level_req(lvl), .capture_pin(pin));
   ctd_timer_support #(.CHANNELS(4)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_pin(pin), .wide_first_tick(tick_a), .wide_second_tick(tick_b),
      .capture_edge_q(edge_q), .capture_latch_q(latch_q), .mod_irq(irq));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) if (latch_q === 1'b1) n_latch <= n_latch + 1;

   task final_report();
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task hang();
      n_fail++;
      $display("wrong value at %0t: no answer within limit", $time);
      final_report();
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      resp_q = bresp;
      bready <= 1'b0;
      if (t == 100) hang();
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (t = 0; t < 100; t++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rd_q = rdata;
      resp_q = rresp;
      rready <= 1'b0;
      if (t == 100) hang();
   endtask
   task pulse(input int p);
      @(posedge aclk);
      if (p == 0) tick_a <= 1'b1;
      else tick_b <= 1'b1;
      @(posedge aclk);
      tick_a <= 1'b0;
      tick_b <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task flip();
      @(posedge aclk);
      lvl[0] <= ~lvl[0];
   endtask
   task edge_wait(input int lim);
      for (t = 0; t < lim; t++) begin
         @(posedge aclk);
         if (edge_q[0] === 1'b1) break;
      end
   endtask
   function automatic int div_of(input int c);
      return (c == 0) ? 1 : (2 << c);
   endfunction
   function automatic int dly_of(input int c);
      return (c == 0) ? 0 : (128 << c);
   endfunction

   initial begin
      n_fail = 0; num_checks = 0; n_latch = 0; seed = 32'hea39c391;
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; tick_a = 1'b0; tick_b = 1'b0; awaddr = 8'h0; araddr = 8'h0;
      wdata = 32'h0; wstrb = 4'hF; lvl = 4'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ctd_pkg::ACCUM_EN_ADDR); chk(rd_q, 32'h0);
      rd(ctd_pkg::MOD_COUNT_ADDR); chk(rd_q, 32'hFFFF);
      rd(8'hA4); chk(resp_q, ctd_pkg::RESP_DECERR);
      wr(8'hA4, 32'h0); chk(resp_q, ctd_pkg::RESP_DECERR);
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h18); chk(resp_q, ctd_pkg::RESP_OKAY);
      rd(ctd_pkg::MOD_CTL_ADDR); chk(rd_q, 32'h0);
      for (k = 0; k < 4; k++) begin
         rnd = $random(seed);
         wr(ctd_pkg::ACCUM_CNT_ADDR, rnd);
         rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, rnd);
      end
      for (k = 0; k < 4; k++) begin
         wr(ctd_pkg::MOD_CTL_ADDR, 32'h0);
         wr(ctd_pkg::MOD_COUNT_ADDR, 32'h6);
         rd(ctd_pkg::MOD_COUNT_ADDR); chk(rd_q, 32'hFFFF);
         wr(ctd_pkg::MOD_FLAGS_ADDR, 32'h80);
         chk(irq, 1'b0);
         wr(ctd_pkg::MOD_CTL_ADDR, 32'h84 | k);
         wr(ctd_pkg::MOD_CTL_ADDR, 32'h8C | k);
         for (t = 0; t < 200; t++) begin
            @(posedge aclk);
            if (irq === 1'b1) break;
         end
         chk(t >= 6 * div_of(k) - 2 && t <= 6 * div_of(k) + 3, 1'b1);
         if (t == 200) hang();
      end
      rd(ctd_pkg::MOD_COUNT_ADDR); chk(rd_q, 32'h0);
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h24);
      rd(ctd_pkg::MOD_COUNT_ADDR); chk(rd_q, 32'h6);
      chk(irq, 1'b0);
      rd(ctd_pkg::MOD_FLAGS_ADDR); chk(rd_q[7], 1'b1);
      wr(ctd_pkg::SYS_CTL_ADDR, 32'h10);
      rd(ctd_pkg::MOD_COUNT_ADDR);
      rd(ctd_pkg::MOD_FLAGS_ADDR); chk(rd_q[7], 1'b0);
      wr(ctd_pkg::SYS_CTL_ADDR, 32'h0);
      // Enable cleared before mode change
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h0);
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h44);
      wr(ctd_pkg::MOD_COUNT_ADDR, 32'h3);
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h4C);
      wr(ctd_pkg::MOD_FLAGS_ADDR, 32'h80);
      repeat (10) @(posedge aclk);
      rd(ctd_pkg::MOD_FLAGS_ADDR); chk(rd_q[7], 1'b1);
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h0);
      wr(ctd_pkg::SYS_CTL_ADDR, 32'hC);
      wr(ctd_pkg::ACCUM_CNT_ADDR, 32'h11223344);
      k = n_latch;
      wr(ctd_pkg::MOD_CTL_ADDR, 32'h10);
      repeat (3) @(posedge aclk);
      chk(n_latch, k + 1);
      rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h0);
      rd(ctd_pkg::ACCUM_HOLD_ADDR); chk(rd_q, 32'h11223344);
      wr(ctd_pkg::ACCUM_CNT_ADDR, 32'h55);
      wr(ctd_pkg::MOD_COUNT_ADDR, 32'h0);
      repeat (3) @(posedge aclk);
      chk(n_latch, k + 2);
      rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h0);
      rd(ctd_pkg::ACCUM_HOLD_ADDR); chk(rd_q, 32'h55);
      for (k = 0; k < 2; k++) begin
         wr(ctd_pkg::SYS_CTL_ADDR, 32'h1 << k);
         wr(ctd_pkg::ACCUM_FLG_ADDR, 32'h3);
         wr(ctd_pkg::ACCUM_CNT_ADDR, 32'h12FF << (16 - 16 * k));
         pulse(k);
         rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h1300 << (16 - 16 * k));
         wr(ctd_pkg::ACCUM_CNT_ADDR, 32'hFFFF << (16 - 16 * k));
         pulse(k);
         rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h0);
         rd(ctd_pkg::ACCUM_FLG_ADDR); chk(rd_q[1:0], 2'h2 >> k);
      end
      wr(ctd_pkg::SYS_CTL_ADDR, 32'h0);
      wr(ctd_pkg::ACCUM_EN_ADDR, 32'h1);
      rd(ctd_pkg::ACCUM_HOLD_ADDR);
      for (k = 0; k < 4; k++) begin
         wr(ctd_pkg::DELAY_CTL_ADDR, k);
         flip();
         edge_wait(dly_of(k) + 20);
         chk(t >= dly_of(k) + 2 && t <= dly_of(k) + 8, 1'b1);
         if (t == dly_of(k) + 20) hang();
      end
      rd(ctd_pkg::MOD_FLAGS_ADDR); chk(rd_q[0], 1'b1);
      rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h4);
      wr(ctd_pkg::DELAY_CTL_ADDR, 32'h1);
      flip();
      repeat (40) @(posedge aclk);
      flip();
      edge_wait(400); chk(t, 400);
      flip();
      edge_wait(300); chk(t >= 258 && t <= 264, 1'b1);
      wr(ctd_pkg::SYS_CTL_ADDR, 32'h2);
      wr(ctd_pkg::DELAY_CTL_ADDR, 32'h0);
      wr(ctd_pkg::ACCUM_CNT_ADDR, 32'h0);
      flip();
      edge_wait(20);
      rd(ctd_pkg::ACCUM_CNT_ADDR); chk(rd_q, 32'h0);
      final_report();
   end
endmodule
